// File: drive_input_command_logic.sv
// Behaviour
// [R1] index zero follows normal frequency source; 1..15 select stored preset
// [R2] preset select inputs weigh 1, 2, 4 and 8; all on gives preset 15
// [R3] ramp select off uses time set 1, on uses time set 2
// [R4] ramp select unassigned always uses time set 1
// [R5] hold on latches first forward/backward run edge; hold off releases it
// [R6] hold unassigned gives two-wire run, only while a run input is on
// [R7] coast stop disables output at once and raises no alarm
// [R8] reset rising edge clears relay; falling edge clears display and hold
// [R9] other party holds reset on at least 10 ms, off normally
// [R10] external trip disables output, shows alarm, drives relay, latched until reset
// [R11] jog-ready input puts the block into jog readiness
// [R12] keypad combo toggles jog readiness unless run source setting is 1
// [R13] jogging uses the inch frequency and inch ramp time
// [R14] keypad jogging runs only while run key stays pressed
// [R15] jog readiness changes only while the motor is stopped
// [R16] jog and run within 100 ms start jogging; else normal run
// [R17] frequency source select off follows source one, on source two
// [R18] frequency source select unassigned always follows source one
// [R19] motor select switches to motor 2 only when stopped; output shows it
// [R20] motor select unassigned selects motor 1
// [R21] switching motor swaps the active motor parameter set
// [R22] each input configurable active high or active low
// [R23] every terminal input is synchronised before decoding
`timescale 1ns/1ps
`include "drive_input_defs.svh"
`default_nettype none

module drive_input_command_logic #(
	parameter int unsigned JOG_WINDOW_CYCLES = `JOG_WINDOW_CYCLES,
	parameter int unsigned SYNC_STAGES       = `SYNC_STAGES
) (
	input  wire logic                         CORE_CLK_I,
	input  wire logic                         RST_B_I,
	input  wire logic [`FN_COUNT-1:0]         TERMINAL_I,
	input  wire logic [`FN_COUNT-1:0]         FUNC_ASSIGNED_I,
	input  wire logic [`FN_COUNT-1:0]         FUNC_ACTIVE_LOW_I,
	input  wire logic [1:0]                   RUN_SOURCE_SETTING_I,
	input  wire logic                         KEY_JOG_COMBO_I,
	input  wire logic                         KEY_RUN_I,
	input  wire logic                         MOTOR_STOPPED_I,
	output drive_input_pkg::speed_cmd_t       SPEED_CMD_O,
	output logic                              RUN_O,
	output logic                              RUN_BACKWARD_O,
	output logic                              OUTPUT_ENABLE_O,
	output logic                              ALARM_RELAY_OUT_O,
	output logic                              ALARM_DISPLAY_O,
	output logic                              ALARM_HOLD_O,
	output logic                              SECOND_MOTOR_ACTIVE_OUT_O,
	output logic                              MOTOR_PARAM_SET_O
);
	import drive_input_pkg::*;

	localparam int WIN_W = $clog2(JOG_WINDOW_CYCLES + 1);

	if (SYNC_STAGES < 2 || JOG_WINDOW_CYCLES < 1) begin : g_bad_param
		$error("sync stages below two or empty jog window");
	end

	// ****************************************************************
	// input synchronisers and sense selection
	// ****************************************************************
	logic [SYNC_STAGES-1:0] sync_ff [`FN_COUNT];
	logic [`FN_COUNT-1:0]   act;
	logic [`FN_COUNT-1:0]   act_prev_ff;
	logic [`FN_COUNT-1:0]   rise;
	logic [`FN_COUNT-1:0]   fall;

	for (genvar i = 0; i < `FN_COUNT; i++) begin : g_sync
		always_ff @(posedge CORE_CLK_I) begin
			if (!RST_B_I) begin
				// reset to the idle sense so no false edge or trip follows reset
				sync_ff[i] <= {SYNC_STAGES{FUNC_ACTIVE_LOW_I[i]}};
			end else begin
				sync_ff[i] <= {sync_ff[i][SYNC_STAGES-2:0], TERMINAL_I[i]}; // R23
			end
		end
		// unassigned functions read as inactive
		assign act[i] = (sync_ff[i][SYNC_STAGES-1] ^ FUNC_ACTIVE_LOW_I[i]) & FUNC_ASSIGNED_I[i]; // R22
	end

	assign rise = act & ~act_prev_ff;
	assign fall = ~act & act_prev_ff;

	// ****************************************************************
	// state
	// ****************************************************************
	run_state_t       run_state_ff, nxt_run_state;
	logic [WIN_W-1:0] win_cnt_ff, nxt_win_cnt;
	logic             latch_run_ff, nxt_latch_run;
	logic             latch_bwd_ff, nxt_latch_bwd;
	logic             jog_ready_ff, nxt_jog_ready;
	logic             key_combo_prev_ff;
	logic             trip_ff, nxt_trip;
	logic             relay_ff, nxt_relay;
	logic             display_ff, nxt_display;
	logic             motor2_ff, nxt_motor2;
	logic             out_en_ff, nxt_out_en;
	logic             run_bwd_ff, nxt_run_bwd;
	speed_cmd_t       speed_ff, nxt_speed;
	logic             three_wire;
	logic             run_req;
	logic             run_bwd_req;
	logic             combo_rise;
	logic             keypad_src;

	assign three_wire = FUNC_ASSIGNED_I[`FN_HOLD];
	assign combo_rise = KEY_JOG_COMBO_I & ~key_combo_prev_ff;
	assign keypad_src = RUN_SOURCE_SETTING_I != `RUN_SRC_TERMINAL;

	// ****************************************************************
	// run command, three-wire latch and jog readiness
	// ****************************************************************
	always_comb begin
		nxt_latch_run = latch_run_ff;
		nxt_latch_bwd = latch_bwd_ff;
		if (!act[`FN_HOLD]) begin
			nxt_latch_run = 1'b0; // R5
		end else if (!latch_run_ff && (rise[`FN_RUN_FWD] || rise[`FN_RUN_BWD])) begin
			nxt_latch_run = 1'b1; // R5
			nxt_latch_bwd = rise[`FN_RUN_BWD] & ~rise[`FN_RUN_FWD];
		end
		run_req     = three_wire ? latch_run_ff : (act[`FN_RUN_FWD] | act[`FN_RUN_BWD]); // R6
		run_bwd_req = three_wire ? latch_bwd_ff : (act[`FN_RUN_BWD] & ~act[`FN_RUN_FWD]);

		nxt_jog_ready = jog_ready_ff;
		if (MOTOR_STOPPED_I && run_state_ff == ST_IDLE) begin // R15
			if (act[`FN_JOG_READY]) begin
				nxt_jog_ready = 1'b1; // R11
			end else if (!keypad_src || fall[`FN_JOG_READY]) begin
				nxt_jog_ready = 1'b0; // R12
			end else if (combo_rise) begin
				nxt_jog_ready = ~jog_ready_ff; // R12
			end
		end

		nxt_run_state = run_state_ff;
		nxt_win_cnt   = win_cnt_ff;
		nxt_run_bwd   = run_bwd_ff;
		unique case (run_state_ff)
			ST_IDLE: begin
				if (jog_ready_ff && keypad_src && KEY_RUN_I) begin
					nxt_run_state = ST_KEY_INCH; // R14
					nxt_run_bwd   = 1'b0;
				end else if (run_req) begin
					nxt_run_bwd = run_bwd_req;
					if (jog_ready_ff || act[`FN_JOG_READY]) begin
						nxt_run_state = ST_INCH; // R16
					end else begin
						nxt_run_state = ST_NORMAL;
						nxt_win_cnt   = WIN_W'(JOG_WINDOW_CYCLES);
					end
				end
			end
			ST_NORMAL: begin
				if (!run_req) begin
					nxt_run_state = ST_IDLE;
					nxt_win_cnt   = '0;
				end else if (win_cnt_ff != '0 && rise[`FN_JOG_READY]) begin
					nxt_run_state = ST_INCH; // R16
					nxt_win_cnt   = '0;
				end else if (win_cnt_ff != '0) begin
					nxt_win_cnt = win_cnt_ff - WIN_W'(1);
				end
			end
			ST_INCH: begin
				if (!run_req) begin
					nxt_run_state = ST_IDLE;
				end
			end
			ST_KEY_INCH: begin
				if (!KEY_RUN_I) begin
					nxt_run_state = ST_IDLE; // R14
				end
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			run_state_ff      <= ST_IDLE;
			win_cnt_ff        <= '0;
			latch_run_ff      <= 1'b0;
			latch_bwd_ff      <= 1'b0;
			jog_ready_ff      <= 1'b0;
			key_combo_prev_ff <= 1'b0;
			act_prev_ff       <= '0;
			run_bwd_ff        <= 1'b0;
		end else begin
			run_state_ff      <= nxt_run_state;
			win_cnt_ff        <= nxt_win_cnt;
			latch_run_ff      <= nxt_latch_run;
			latch_bwd_ff      <= nxt_latch_bwd;
			jog_ready_ff      <= nxt_jog_ready;
			key_combo_prev_ff <= KEY_JOG_COMBO_I;
			act_prev_ff       <= act;
			run_bwd_ff        <= nxt_run_bwd;
		end
	end

	// ****************************************************************
	// alarm, output enable, motor and speed selection
	// ****************************************************************
	always_comb begin
		nxt_trip    = trip_ff;
		nxt_relay   = relay_ff;
		nxt_display = display_ff;
		if (rise[`FN_ALARM_RESET]) begin
			nxt_relay = 1'b0; // R8
		end
		if (fall[`FN_ALARM_RESET]) begin
			nxt_trip    = 1'b0; // R8
			nxt_display = 1'b0;
		end
		// a trip in the clearing cycle wins
		if (act[`FN_TRIP]) begin
			nxt_trip    = 1'b1; // R10
			nxt_relay   = 1'b1;
			nxt_display = 1'b1;
		end
		nxt_out_en = ~(act[`FN_COAST] | act[`FN_TRIP] | nxt_trip); // R7 R10

		nxt_motor2 = motor2_ff;
		if (MOTOR_STOPPED_I && run_state_ff == ST_IDLE) begin
			nxt_motor2 = act[`FN_MOTOR_SEL]; // R19 R20 R21
		end

		nxt_speed.preset_index    = {act[`FN_SEL_W8], act[`FN_SEL_W4],
			act[`FN_SEL_W2], act[`FN_SEL_W1]}; // R2
		nxt_speed.use_preset      = nxt_speed.preset_index != `PRESET_NONE; // R1
		nxt_speed.freq_source_two = act[`FN_FREQ_SEL]; // R17 R18
		nxt_speed.ramp_set_two    = act[`FN_RAMP_SEL]; // R3 R4
		nxt_speed.inch            = nxt_run_state == ST_INCH || nxt_run_state == ST_KEY_INCH; // R13
	end

	always_ff @(posedge CORE_CLK_I) begin
		if (!RST_B_I) begin
			trip_ff    <= 1'b0;
			relay_ff   <= 1'b0;
			display_ff <= 1'b0;
			out_en_ff  <= 1'b0;
			motor2_ff  <= 1'b0;
			speed_ff   <= '0;
		end else begin
			trip_ff    <= nxt_trip;
			relay_ff   <= nxt_relay;
			display_ff <= nxt_display;
			out_en_ff  <= nxt_out_en;
			motor2_ff  <= nxt_motor2;
			speed_ff   <= nxt_speed;
		end
	end

	assign SPEED_CMD_O               = speed_ff;
	assign RUN_O                     = run_state_ff != ST_IDLE;
	assign RUN_BACKWARD_O            = run_bwd_ff;
	assign OUTPUT_ENABLE_O           = out_en_ff;
	assign ALARM_RELAY_OUT_O         = relay_ff;
	assign ALARM_DISPLAY_O           = display_ff;
	assign ALARM_HOLD_O              = trip_ff;
	assign SECOND_MOTOR_ACTIVE_OUT_O = motor2_ff;
	assign MOTOR_PARAM_SET_O         = motor2_ff;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_B_I);

	coast_disables_a: assert property (act[`FN_COAST] |=> !OUTPUT_ENABLE_O) // R7
		else $error("coast did not disable output");
	coast_no_alarm_a: assert property (act[`FN_COAST] && !act[`FN_TRIP] // R7
		|=> !$rose(ALARM_RELAY_OUT_O)) else $error("coast raised the alarm relay");
	out_restore_a: assert property (!act[`FN_COAST] && !act[`FN_TRIP] && !ALARM_HOLD_O // R7
		|=> OUTPUT_ENABLE_O) else $error("output stayed disabled");
	trip_latches_a: assert property (act[`FN_TRIP] // R10
		|=> ALARM_RELAY_OUT_O && ALARM_HOLD_O && ALARM_DISPLAY_O && !OUTPUT_ENABLE_O)
		else $error("trip not latched");
	trip_holds_a: assert property (ALARM_HOLD_O && !fall[`FN_ALARM_RESET] // R10
		|=> ALARM_HOLD_O) else $error("trip released without reset");
	reset_relay_a: assert property (rise[`FN_ALARM_RESET] && !act[`FN_TRIP] // R8
		|=> !ALARM_RELAY_OUT_O) else $error("reset edge left relay on");
	relay_stays_a: assert property (ALARM_RELAY_OUT_O && !rise[`FN_ALARM_RESET] // R8
		|=> ALARM_RELAY_OUT_O) else $error("relay cleared without reset edge");
	preset_index_a: assert property (1'b1 // R1 R2
		|=> SPEED_CMD_O.preset_index == {$past(act[`FN_SEL_W8]), $past(act[`FN_SEL_W4]),
		$past(act[`FN_SEL_W2]), $past(act[`FN_SEL_W1])}
		&& SPEED_CMD_O.use_preset == (SPEED_CMD_O.preset_index != `PRESET_NONE))
		else $error("preset index wrong");
	ramp_select_a: assert property (1'b1 // R3 R17
		|=> SPEED_CMD_O.ramp_set_two == $past(act[`FN_RAMP_SEL])
		&& SPEED_CMD_O.freq_source_two == $past(act[`FN_FREQ_SEL]))
		else $error("ramp or source select wrong");
	motor_stable_a: assert property (!MOTOR_STOPPED_I // R19
		|=> $stable(SECOND_MOTOR_ACTIVE_OUT_O)) else $error("motor switched while running");
	motor_follows_a: assert property (MOTOR_STOPPED_I && run_state_ff == ST_IDLE // R19 R21
		|=> SECOND_MOTOR_ACTIVE_OUT_O == $past(act[`FN_MOTOR_SEL])
		&& MOTOR_PARAM_SET_O == SECOND_MOTOR_ACTIVE_OUT_O) else $error("motor select not followed");
	hold_release_a: assert property (three_wire && !act[`FN_HOLD] // R5
		|=> !latch_run_ff) else $error("hold off did not release latch");
	hold_latches_a: assert property (act[`FN_HOLD] && !latch_run_ff && rise[`FN_RUN_FWD] // R5
		|=> latch_run_ff) else $error("run edge not latched under hold");
	two_wire_run_a: assert property (!three_wire && act[`FN_RUN_FWD] // R6
		&& run_state_ff == ST_IDLE |=> RUN_O) else $error("two-wire run not started");
	jog_gated_a: assert property (!(MOTOR_STOPPED_I && run_state_ff == ST_IDLE) // R15
		|=> $stable(jog_ready_ff)) else $error("jog readiness changed while running");
	combo_ignored_a: assert property (MOTOR_STOPPED_I && run_state_ff == ST_IDLE // R12
		&& !keypad_src && !act[`FN_JOG_READY] |=> !jog_ready_ff)
		else $error("jog readiness kept with terminal run source");
	inch_window_a: assert property (run_state_ff == ST_NORMAL && win_cnt_ff != '0 // R16
		&& rise[`FN_JOG_READY] && run_req |=> run_state_ff == ST_INCH ##0 SPEED_CMD_O.inch)
		else $error("jog in window not taken");
	key_inch_stop_a: assert property (run_state_ff == ST_KEY_INCH && !KEY_RUN_I // R14
		|=> !RUN_O) else $error("keypad jog kept running");

	trip_reset_c: cover property (ALARM_HOLD_O ##[1:1000] !ALARM_HOLD_O);
	window_inch_c: cover property (run_state_ff == ST_NORMAL ##1 run_state_ff == ST_INCH);
	key_inch_c: cover property (run_state_ff == ST_KEY_INCH);
	motor_switch_c: cover property ($rose(SECOND_MOTOR_ACTIVE_OUT_O));
	hold_latch_c: cover property (latch_run_ff && !act[`FN_RUN_FWD]);

endmodule

`default_nettype wire

// File: drive_input_defs.svh
`ifndef DRIVE_INPUT_DEFS_SVH
`define DRIVE_INPUT_DEFS_SVH

// ****************************************************************
// terminal function slots
// ****************************************************************
`define FN_SEL_W1       0
`define FN_SEL_W2       1
`define FN_SEL_W4       2
`define FN_SEL_W8       3
`define FN_RAMP_SEL     4
`define FN_HOLD         5
`define FN_COAST        6
`define FN_ALARM_RESET  7
`define FN_TRIP         8
`define FN_JOG_READY    9
`define FN_FREQ_SEL     10
`define FN_MOTOR_SEL    11
`define FN_RUN_FWD      12
`define FN_RUN_BWD      13
`define FN_COUNT        14

// ****************************************************************
// settings and timing
// ****************************************************************
`define RUN_SRC_TERMINAL 2'h1
`define PRESET_NONE      4'h0
`define SYNC_STAGES      2
`define CORE_CLK_HZ      200000000
`define JOG_WINDOW_MS    100
`define JOG_WINDOW_CYCLES ((`CORE_CLK_HZ / 1000) * `JOG_WINDOW_MS)

`endif

// File: drive_input_pkg.sv
`default_nettype none

package drive_input_pkg;

	typedef struct packed {
		logic       use_preset;
		logic [3:0] preset_index;
		logic       freq_source_two;
		logic       ramp_set_two;
		logic       inch;
	} speed_cmd_t;

	typedef enum logic [1:0] {
		ST_IDLE     = 2'b00,
		ST_NORMAL   = 2'b01,
		ST_INCH     = 2'b10,
		ST_KEY_INCH = 2'b11
	} run_state_t;

endpackage

`default_nettype wire

// File: drive_switch_panel.sv
`timescale 1ns/1ps
`include "drive_input_defs.svh"
`default_nettype none

// ****
// external switches driving the terminals
// ****
module drive_switch_panel #(
	parameter int unsigned RESET_HOLD = 40
) (
	input  wire logic                 clk_i,
	input  wire logic                 rst_b_i,
	input  wire logic [`FN_COUNT-1:0] level_i,
	input  wire logic [`FN_COUNT-1:0] active_low_i,
	input  wire logic                 reset_pulse_i,
	output logic      [`FN_COUNT-1:0] terminal_o
);
	logic [15:0]          hold_ff;
	logic [15:0]          nxt_hold;
	logic [`FN_COUNT-1:0] asserted;

	// reset press is stretched; the full width is shortened from 2,000,000 cycles
	always_comb begin
		nxt_hold = hold_ff;
		if (reset_pulse_i && hold_ff == 16'h0) begin
			nxt_hold = 16'(RESET_HOLD);
		end else if (hold_ff != 16'h0) begin
			nxt_hold = hold_ff - 16'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_b_i) begin
			hold_ff <= 16'h0;
		end else begin
			hold_ff <= nxt_hold;
		end
	end

	always_comb begin
		asserted = level_i;
		asserted[`FN_ALARM_RESET] = level_i[`FN_ALARM_RESET] | (hold_ff != 16'h0);
		terminal_o = asserted ^ active_low_i;
	end
endmodule

`default_nettype wire

// File: drive_input_command_logic_test.sv
`timescale 1ns/1ps
`include "drive_input_defs.svh"
`default_nettype none

// ****
// directed bench
// ****
module drive_input_command_logic_test;
	import drive_input_pkg::*;
	logic clk, rst_b, combo, key_run, stopped, pulse, run, bwd, oe, relay, disp, hold, m2, mp;
	logic [`FN_COUNT-1:0] level, assigned, act_low, terminal;
	logic [1:0] run_src;
	speed_cmd_t speed;
	int errors, n_checks, cycles;

	drive_switch_panel #(.RESET_HOLD(40)) panel (.clk_i(clk), .rst_b_i(rst_b), .level_i(level),
		.active_low_i(act_low), .reset_pulse_i(pulse), .terminal_o(terminal));

	drive_input_command_logic #(.JOG_WINDOW_CYCLES(20), .SYNC_STAGES(2)) dut (
		.CORE_CLK_I(clk), .RST_B_I(rst_b), .TERMINAL_I(terminal), .FUNC_ASSIGNED_I(assigned),
		.FUNC_ACTIVE_LOW_I(act_low), .RUN_SOURCE_SETTING_I(run_src), .KEY_JOG_COMBO_I(combo),
		.KEY_RUN_I(key_run), .MOTOR_STOPPED_I(stopped), .SPEED_CMD_O(speed), .RUN_O(run),
		.RUN_BACKWARD_O(bwd), .OUTPUT_ENABLE_O(oe), .ALARM_RELAY_OUT_O(relay),
		.ALARM_DISPLAY_O(disp), .ALARM_HOLD_O(hold), .SECOND_MOTOR_ACTIVE_OUT_O(m2),
		.MOTOR_PARAM_SET_O(mp));

	task automatic finish_test();
		if (errors == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic check1(input logic seen, input logic exp);
		check({7'h0, seen}, {7'h0, exp});
	endtask

	// three edges through the two synchroniser stages and the output register plus margin
	task automatic settle();
		repeat (5) @(posedge clk);
		#1;
	endtask

	task automatic put(input int fn, input logic v);
		@(posedge clk);
		level[fn] <= v;
		settle();
	endtask

	task automatic press_combo();
		@(posedge clk);
		combo <= 1'b1;
		@(posedge clk);
		combo <= 1'b0;
		settle();
	endtask

	task automatic test_speed();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			level[3:0] <= i[3:0];
			settle();
			check1(speed.use_preset, i != 0);
			check({4'h0, speed.preset_index}, {4'h0, i[3:0]});
		end
		put(`FN_RAMP_SEL, 1'b1);
		put(`FN_FREQ_SEL, 1'b1);
		check1(speed.ramp_set_two, 1'b1);
		check1(speed.freq_source_two, 1'b1);
		@(posedge clk);
		assigned[`FN_RAMP_SEL] <= 1'b0;
		assigned[`FN_FREQ_SEL] <= 1'b0;
		settle();
		check1(speed.ramp_set_two, 1'b0);
		check1(speed.freq_source_two, 1'b0);
		@(posedge clk);
		assigned <= '1;
		level <= '0;
		settle();
		check1(speed.ramp_set_two, 1'b0);
	endtask

	task automatic test_run();
		@(posedge clk);
		assigned[`FN_HOLD] <= 1'b0;
		put(`FN_RUN_FWD, 1'b1);
		check1(run, 1'b1);
		check1(bwd, 1'b0);
		put(`FN_RUN_FWD, 1'b0);
		check1(run, 1'b0);
		put(`FN_RUN_BWD, 1'b1);
		check1(bwd, 1'b1);
		put(`FN_RUN_BWD, 1'b0);
		@(posedge clk);
		assigned[`FN_HOLD] <= 1'b1;
		put(`FN_HOLD, 1'b1);
		put(`FN_RUN_FWD, 1'b1);
		put(`FN_RUN_FWD, 1'b0);
		check1(run, 1'b1);
		put(`FN_HOLD, 1'b0);
		check1(run, 1'b0);
		@(posedge clk);
		assigned[`FN_HOLD] <= 1'b0;
	endtask

	task automatic test_alarm();
		put(`FN_COAST, 1'b1);
		check1(oe, 1'b0);
		check1(relay, 1'b0);
		put(`FN_COAST, 1'b0);
		check1(oe, 1'b1);
		put(`FN_TRIP, 1'b1);
		put(`FN_TRIP, 1'b0);
		check({4'h0, relay, disp, hold, oe}, 8'h0e);
		@(posedge clk);
		pulse <= 1'b1;
		@(posedge clk);
		pulse <= 1'b0;
		repeat (8) @(posedge clk);
		#1;
		check({6'h0, relay, disp}, 8'h01);
		repeat (48) @(posedge clk);
		#1;
		check({5'h0, disp, hold, oe}, 8'h01);
	endtask

	task automatic test_jog();
		put(`FN_JOG_READY, 1'b1);
		put(`FN_RUN_FWD, 1'b1);
		check({6'h0, run, speed.inch}, 8'h03);
		put(`FN_RUN_FWD, 1'b0);
		put(`FN_JOG_READY, 1'b0);
		put(`FN_RUN_FWD, 1'b1);
		check1(speed.inch, 1'b0);
		put(`FN_JOG_READY, 1'b1);
		check1(speed.inch, 1'b1);
		put(`FN_RUN_FWD, 1'b0);
		put(`FN_JOG_READY, 1'b0);
		press_combo();
		@(posedge clk);
		key_run <= 1'b1;
		settle();
		check({6'h0, run, speed.inch}, 8'h03);
		@(posedge clk);
		key_run <= 1'b0;
		run_src <= `RUN_SRC_TERMINAL;
		settle();
		check1(run, 1'b0);
		press_combo();
		@(posedge clk);
		key_run <= 1'b1;
		settle();
		check1(run, 1'b0);
		@(posedge clk);
		key_run <= 1'b0;
		run_src <= 2'h0;
		stopped <= 1'b0;
		press_combo();
		@(posedge clk);
		stopped <= 1'b1;
		key_run <= 1'b1;
		settle();
		check1(run, 1'b0);
		@(posedge clk);
		key_run <= 1'b0;
	endtask

	task automatic test_motor();
		@(posedge clk);
		stopped <= 1'b0;
		put(`FN_MOTOR_SEL, 1'b1);
		check1(m2, 1'b0);
		@(posedge clk);
		stopped <= 1'b1;
		settle();
		check({6'h0, m2, mp}, 8'h03);
		@(posedge clk);
		assigned[`FN_MOTOR_SEL] <= 1'b0;
		settle();
		check({6'h0, m2, mp}, 8'h00);
	endtask

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	initial begin
		errors = 0;
		n_checks = 0;
		cycles = 0;
		rst_b = 1'b0;
		level = '0;
		assigned = '1;
		act_low = '0;
		act_low[`FN_TRIP] = 1'b1;
		run_src = 2'h0;
		combo = 1'b0;
		key_run = 1'b0;
		stopped = 1'b1;
		pulse = 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		settle();
		test_speed();
		test_run();
		test_alarm();
		test_jog();
		test_motor();
		finish_test();
	end
endmodule

`default_nettype wire
